//--- design/p9g_port9.sv
// Port 9 GPIO with pin multiplexing and AXI4-Lite register access
`timescale 1ns/10ps
`include "p9g_defs.svh"
module p9g_port9
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // Chip state
   input wire logic [1:0] op_mode,
   input wire logic slave_mode,
   input wire logic hw_standby,
   // Peripheral sources
   input wire logic sys_clk_out,
   input wire logic address_strobe_in,
   input wire logic write_strobe_in,
   input wire logic read_strobe_in,
   input wire logic iic_sda_out,
   input wire logic iic_sda_oe,
   // Pins
   input wire logic [7:0] pin_i,
   output logic [7:0] pin_o,
   output logic [7:0] pin_oe,
   // Peripheral sinks
   output logic wait_in,
   output logic iic_sda_in,
   output logic ext_int_pin0,
   output logic ext_int_pin1,
   output logic ext_int_pin2,
   output logic adc_trigger_pin,
   output logic host_write_strobe,
   output logic host_chip_select2,
   // AXI4-Lite slave
   input wire logic [15:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [15:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   logic [7:0] pin_m_q;
   logic [7:0] pin_s_q;
   logic [7:0] dir_q;
   logic [7:0] latch_q;
   logic [7:0] ctrl_q;
   logic [1:0] mode_q;
   logic mode12;
   logic host_sel;
   logic wait_sel;
   logic iic_sel;
   logic [7:0] oe_d;
   logic [7:0] out_d;
   logic [15:0] aw_q;
   logic aw_have_q;
   logic [7:0] wd_q;
   logic w_have_q;
   logic wbe_q;
   p9g_pkg::p9g_bus_st_t wr_st_q;
   logic wr_go;
   logic wr_hit;

   // Mode is taken by a clocked process so op_mode never enters the reset path
   always_ff @(posedge ref_clk)
      mode_q <= op_mode;

   // Pins are asynchronous: two stages before any logic looks at them
   always_ff @(posedge ref_clk)
   begin
      pin_m_q <= pin_i;
      pin_s_q <= pin_m_q;
   end

   assign mode12 = (mode_q != 2'(p9g_pkg::P9G_MODE3));
   assign host_sel = slave_mode & ctrl_q[`P9G_CTRL_HOST_STROBE_SELECT_BIT];
   assign wait_sel = mode12 & ctrl_q[`P9G_CTRL_WAIT_BIT];
   assign iic_sel = ~wait_sel & ctrl_q[`P9G_CTRL_IIC_BIT];

   // Write channel: address and data may arrive in either order
   assign wr_go = aw_have_q & w_have_q & (wr_st_q == p9g_pkg::P9G_IDLE);
   assign wr_hit = wr_go & wbe_q; // A write without byte 0 is answered but changes nothing

   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         aw_have_q <= 1'b0;
         aw_q <= 16'h0000;
         s_axi_awready <= 1'b0;
      end
      else if (s_axi_awvalid & s_axi_awready)
      begin
         aw_q <= s_axi_awaddr;
         aw_have_q <= 1'b1;
         s_axi_awready <= 1'b0;
      end
      else if (wr_go)
      begin
         aw_have_q <= 1'b0;
      end
      else
      begin
         s_axi_awready <= ~aw_have_q & (wr_st_q == p9g_pkg::P9G_IDLE);
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         w_have_q <= 1'b0;
         wd_q <= 8'h00;
         wbe_q <= 1'b0;
         s_axi_wready <= 1'b0;
      end
      else if (s_axi_wvalid & s_axi_wready)
      begin
         wd_q <= s_axi_wdata[7:0];
         w_have_q <= 1'b1;
         wbe_q <= s_axi_wstrb[0];
         s_axi_wready <= 1'b0;
      end
      else if (wr_go)
      begin
         w_have_q <= 1'b0;
      end
      else
      begin
         s_axi_wready <= ~w_have_q & (wr_st_q == p9g_pkg::P9G_IDLE);
      end
   end

   // Write response, OKAY for mapped offsets, SLVERR elsewhere
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         wr_st_q <= p9g_pkg::P9G_IDLE;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end
      else
      begin
         case (wr_st_q)
            p9g_pkg::P9G_IDLE:
               if (wr_go)
               begin
                  wr_st_q <= p9g_pkg::P9G_RESP;
                  s_axi_bvalid <= 1'b1;
                  if (aw_q == `P9G_DIR_OFFSET || aw_q == `P9G_LATCH_OFFSET
                      || aw_q == `P9G_CTRL_OFFSET)
                     s_axi_bresp <= 2'h0;
                  else
                     s_axi_bresp <= 2'h2;
               end
            default:
               if (s_axi_bready)
               begin
                  wr_st_q <= p9g_pkg::P9G_IDLE;
                  s_axi_bvalid <= 1'b0;
               end
         endcase
      end
   end

   // Direction register; hardware standby reloads it, software standby keeps it
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n || hw_standby)
         dir_q <= `P9G_DIR_RESET_M3; // Mode-dependent bit 6 added below
      else if (wr_hit && aw_q == `P9G_DIR_OFFSET && w_have_q)
         dir_q <= wd_q;
   end

   // Control register of enables and standby flag
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
         ctrl_q <= 8'h00;
      else if (wr_hit && aw_q == `P9G_CTRL_OFFSET)
         ctrl_q <= wd_q;
   end

   // Data latch; bit 6 has no storage worth keeping since it reads the pin
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n || hw_standby)
         latch_q <= `P9G_LATCH_RESET;
      else if (wr_hit && aw_q == `P9G_LATCH_OFFSET)
         latch_q <= wd_q;
   end

   // Effective direction: bit 6 forced high in modes 1 and 2, ignoring writes
   function automatic logic [7:0] p9g_eff_dir(input logic [7:0] d, input logic m12);
      logic [7:0] r;
      r = d;
      if (m12)
         r[`P9G_CLK_BIT] = 1'b1;
      return r;
   endfunction

   // Pin ownership and drive
   always_comb
   begin
      oe_d = p9g_eff_dir(dir_q, mode12);
      out_d = latch_q;
      out_d[`P9G_CLK_BIT] = sys_clk_out;
      if (wait_sel)
         oe_d[7] = 1'b0;
      else if (iic_sel)
      begin
         oe_d[7] = iic_sda_oe;
         out_d[7] = iic_sda_out;
      end
      if (mode12)
      begin
         oe_d[5:3] = 3'h7;
         out_d[5] = address_strobe_in;
         out_d[4] = write_strobe_in;
         out_d[3] = read_strobe_in;
      end
      if (host_sel)
         oe_d[1:0] = 2'h0;
   end

   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         pin_oe <= 8'h00;
         pin_o <= 8'h00;
      end
      else
      begin
         pin_oe <= oe_d;
         pin_o <= out_d;
      end
   end

   // Input functions fed from synchronised pins (active-low lines pass as is)
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         wait_in <= 1'b1;
         iic_sda_in <= 1'b1;
         ext_int_pin0 <= 1'b1;
         ext_int_pin1 <= 1'b1;
         ext_int_pin2 <= 1'b1;
         adc_trigger_pin <= 1'b1;
         host_write_strobe <= 1'b1;
         host_chip_select2 <= 1'b1;
      end
      else
      begin
         wait_in <= wait_sel ? pin_s_q[7] : 1'b1;
         iic_sda_in <= iic_sel ? pin_s_q[7] : 1'b1;
         ext_int_pin0 <= ctrl_q[`P9G_CTRL_INT0_BIT] ? pin_s_q[2] : 1'b1;
         ext_int_pin1 <= ctrl_q[`P9G_CTRL_INT1_BIT] ? pin_s_q[1] : 1'b1;
         ext_int_pin2 <= ctrl_q[`P9G_CTRL_INT2_BIT] ? pin_s_q[0] : 1'b1;
         adc_trigger_pin <= (ctrl_q[`P9G_CTRL_TRG_BIT] & ~host_sel) ? pin_s_q[0] : 1'b1;
         host_write_strobe <= host_sel ? pin_s_q[1] : 1'b1;
         host_chip_select2 <= host_sel ? pin_s_q[0] : 1'b1;
      end
   end

   // Read channel, one cycle from address to data
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= 2'h0;
      end
      else if (s_axi_rvalid)
      begin
         if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b0;
      end
      else if (s_axi_arvalid & s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= 2'h0;
         if (s_axi_araddr == `P9G_DIR_OFFSET)
            s_axi_rdata <= {24'h000000, 8'hFF};
         else if (s_axi_araddr == `P9G_LATCH_OFFSET)
         begin
            // Output bits other than 6 show the latch, inputs and bit 6 the pin, for any owner
            s_axi_rdata[7:0] <= (p9g_eff_dir(dir_q, mode12) & latch_q)
                              | (~p9g_eff_dir(dir_q, mode12) & pin_s_q);
            s_axi_rdata[`P9G_CLK_BIT] <= pin_s_q[`P9G_CLK_BIT];
            s_axi_rdata[31:8] <= 24'h000000;
         end
         else if (s_axi_araddr == `P9G_CTRL_OFFSET)
            s_axi_rdata <= {24'h000000, ctrl_q};
         else
         begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h2;
         end
      end
      else
         s_axi_arready <= 1'b1;
   end
endmodule

//--- inc/p9g_defs.svh
// Port 9 register offsets, reset values and bit positions
`ifndef P9G_DEFS_SVH
`define P9G_DEFS_SVH
`define P9G_DIR_OFFSET 16'hFFC0
`define P9G_LATCH_OFFSET 16'hFFC1
`define P9G_DIR_RESET_M12 8'h40
`define P9G_DIR_RESET_M3 8'h00
`define P9G_LATCH_RESET 8'h00
`define P9G_CLK_BIT 6
`define P9G_CTRL_OFFSET 16'hFFC4
`define P9G_CTRL_WAIT_BIT 0
`define P9G_CTRL_IIC_BIT 1
`define P9G_CTRL_HOST_STROBE_SELECT_BIT 2
`define P9G_CTRL_INT0_BIT 3
`define P9G_CTRL_INT1_BIT 4
`define P9G_CTRL_INT2_BIT 5
`define P9G_CTRL_TRG_BIT 6
`define P9G_CTRL_SSTBY_BIT 7
`endif

//--- inc/p9g_pkg.sv
// Port 9 shared types
package p9g_pkg;
   typedef enum logic [1:0] {P9G_MODE1, P9G_MODE2, P9G_MODE3, P9G_MODE_RSV} p9g_mode_t;
   typedef enum logic {P9G_IDLE, P9G_RESP} p9g_bus_st_t;
endpackage

//--- tb/p9g_port9_sva.sv
// Assertions on port 9 pin ownership and register reads
`timescale 1ns/10ps
module p9g_port9_sva
(
   // Clock, reset and mode
   input logic ref_clk,
   input logic reset_n,
   input logic [1:0] op_mode,
   // Pins and function sinks
   input logic [7:0] pin_i,
   input logic [7:0] pin_oe,
   input logic wait_in,
   input logic ext_int_pin0,
   input logic ext_int_pin2,
   input logic host_write_strobe,
   input logic host_chip_select2,
   // Read channel
   input logic [15:0] s_axi_araddr,
   input logic s_axi_arvalid,
   input logic s_axi_arready,
   input logic s_axi_rvalid,
   input logic [31:0] s_axi_rdata
);
   logic [1:0] m12_q;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   // Cycles spent in mode 1 or 2; pin enables lag the mode by two cycles
   always_ff @(posedge ref_clk)
      if (!reset_n || op_mode == 2'h2) m12_q <= 2'h0;
      else if (m12_q != 2'h3) m12_q <= m12_q + 2'h1;
   property p_dir_rd;
      s_axi_arvalid && s_axi_arready && s_axi_araddr == 16'hFFC0
         |=> s_axi_rvalid && s_axi_rdata == 32'h000000FF;
   endproperty
   a_dir_rd: assert property (p_dir_rd) else $error("direction read");
   property p_clk_oe;
      m12_q == 2'h3 |-> pin_oe[6];
   endproperty
   a_clk_oe: assert property (p_clk_oe) else $error("clock pin");
   property p_strb_oe;
      m12_q == 2'h3 |-> pin_oe[5:3] == 3'h7;
   endproperty
   a_strb_oe: assert property (p_strb_oe) else $error("strobe pins");
   property p_wait_off;
      !wait_in |-> !pin_oe[7];
   endproperty
   a_wait_off: assert property (p_wait_off) else $error("wait pin driven");
   property p_hws_off;
      !host_write_strobe |-> !pin_oe[1];
   endproperty
   a_hws_off: assert property (p_hws_off) else $error("pin 1 driven");
   property p_cs2_off;
      !host_chip_select2 |-> !pin_oe[0];
   endproperty
   a_cs2_off: assert property (p_cs2_off) else $error("pin 0 driven");
   // Interrupt copies trail the pin by the synchroniser and one register
   property p_int0;
      $fell(ext_int_pin0) |-> !$past(pin_i[2], 2) || !$past(pin_i[2], 3);
   endproperty
   a_int0: assert property (p_int0) else $error("int 0 source");
   property p_int2;
      $fell(ext_int_pin2) |-> !$past(pin_i[0], 2) || !$past(pin_i[0], 3);
   endproperty
   a_int2: assert property (p_int2) else $error("int 2 source");
   c_rd: cover property (s_axi_rvalid);
   c_hws: cover property (!host_write_strobe);
   c_wait: cover property (!wait_in);
endmodule
bind p9g_port9 p9g_port9_sva u_sva (.*);

//--- tb/p9g_pins_model.sv
// Board wiring seen at the port 9 pins
`timescale 1ns/10ps
module p9g_pins_model
(
   // Device drive
   input logic [7:0] pin_o,
   input logic [7:0] pin_oe,
   // Board levels on undriven pins
   input logic [7:0] ext_lvl,
   // Resolved levels
   output logic [7:0] pin_i
);
   // A driven pin reads its own drive, any other the board level
   assign pin_i = (pin_o & pin_oe) | (ext_lvl & ~pin_oe);
endmodule

//--- tb/tb_p9g_port9.sv
// Self-checking bench for the port 9 pin multiplexer
`timescale 1ns/10ps
`define CK(a, b) begin num_checks++; if ((a) !== (b)) begin error_cnt++; \
   $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module tb_p9g_port9;
   logic ref_clk = 0, reset_n = 0, slave_mode = 0, hw_standby = 0, sys_clk_out = 1;
   logic address_strobe_in = 0, write_strobe_in = 0, read_strobe_in = 0;
   logic iic_sda_out = 0, iic_sda_oe = 0, wait_in, iic_sda_in, adc_trigger_pin;
   logic ext_int_pin0, ext_int_pin1, ext_int_pin2, host_write_strobe, host_chip_select2;
   logic [1:0] op_mode = 0, s_axi_bresp, s_axi_rresp, rsp;
   logic [7:0] pin_i, pin_o, pin_oe, ext_lvl = 8'h3F, r = 8'h62, d, l, rd_q;
   logic [15:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid;
   int error_cnt = 0, num_checks = 0, cyc = 0;
   always #50 ref_clk = ~ref_clk;
   p9g_port9 dut (.*);
   p9g_pins_model u_pins (.pin_o(pin_o), .pin_oe(pin_oe), .ext_lvl(ext_lvl), .pin_i(pin_i));
   function automatic logic [7:0] nx(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   // Data read: latch where driven, pin elsewhere, bit 6 always the live pin
   function automatic logic [7:0] exp_rd(input logic [7:0] dd, ll, ee, input logic ck);
      logic [7:0] v;
      v = (dd & ll) | (~dd & ee);
      v[6] = dd[6] ? ck : ee[6];
      return v;
   endfunction
   task automatic test_done;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Watchdog well above the few hundred cycles the run needs
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         error_cnt++;
         test_done();
      end
   end
   task automatic st;
      repeat (6) @(posedge ref_clk);
      #1;
   endtask
   // Write: address and data offered together, each dropped once taken
   task automatic wr(input logic [15:0] a, input logic [7:0] v);
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, v};
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do
      begin
         @(posedge ref_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (!s_axi_bvalid);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'h0;
   endtask
   task automatic rd(input logic [15:0] a);
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do
      begin
         @(posedge ref_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (!s_axi_rvalid);
      rd_q = s_axi_rdata[7:0];
      rsp = s_axi_rresp;
      s_axi_rready <= 1'h0;
   endtask
   task automatic rst;
      @(posedge ref_clk);
      reset_n <= 1'h0;
      repeat (10) @(posedge ref_clk);
      reset_n <= 1'h1;
      st();
   endtask
   initial
   begin
      // Mode 1: clock and strobes own pins 6 to 3, wait input on pin 7
      rst();
      `CK(pin_oe, 8'h78)
      rd(16'hFFC0);
      `CK(rd_q, 8'hFF)
      rd(16'hFF00);
      `CK(rsp, 2'h2)
      wr(16'hFF02, 8'h55);
      `CK(rsp, 2'h2)
      wr(16'hFFC4, 8'h01);
      `CK(rsp, 2'h0)
      wr(16'hFFC0, 8'hFF);
      {address_strobe_in, write_strobe_in, read_strobe_in} <= 3'h5;
      st();
      `CK(pin_oe, 8'h7F)
      `CK(pin_o[5:3], 3'h5)
      `CK(wait_in, 1'h0)
      rd(16'hFFC1);
      `CK(rd_q, 8'h40)
      wr(16'hFFC0, 8'h00);
      st();
      `CK(pin_oe, 8'h78)
      // Mode 3: random direction, latch and board levels, corners first
      @(posedge ref_clk);
      op_mode <= 2'h2;
      rst();
      `CK(pin_oe, 8'h00)
      for (int i = 0; i < 24; i++)
      begin
         r = nx(r);
         d = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : r;
         r = nx(r);
         l = r;
         r = nx(r);
         @(posedge ref_clk);
         ext_lvl <= r;
         {sys_clk_out, address_strobe_in, write_strobe_in, read_strobe_in} <= r[3:0];
         wr(16'hFFC0, d);
         wr(16'hFFC1, l);
         st();
         `CK(pin_oe, d)
         `CK(pin_o & d & 8'hBF, l & d & 8'hBF)
         rd(16'hFFC1);
         `CK(rd_q, exp_rd(d, l, r, sys_clk_out))
      end
      // Hardware standby reloads direction and clears the latch
      @(posedge ref_clk);
      hw_standby <= 1'h1;
      ext_lvl <= 8'h00;
      st();
      `CK(pin_oe, 8'h00)
      @(posedge ref_clk);
      hw_standby <= 1'h0;
      wr(16'hFFC0, 8'hFF);
      st();
      rd(16'hFFC1);
      `CK(rd_q, exp_rd(8'hFF, 8'h00, 8'h00, sys_clk_out))
      // Software standby keeps both registers; a strobe-less write lands nowhere
      wr(16'hFFC1, 8'hA5);
      s_axi_wstrb <= 4'h0;
      wr(16'hFFC1, 8'h3C);
      s_axi_wstrb <= 4'hF;
      wr(16'hFFC4, 8'h80);
      st();
      `CK(pin_oe, 8'hFF)
      rd(16'hFFC1);
      `CK(rd_q, exp_rd(8'hFF, 8'hA5, 8'h00, sys_clk_out))
      wr(16'hFFC1, 8'h00);
      // Slave mode with host strobes, interrupts and trigger enabled
      @(posedge ref_clk);
      slave_mode <= 1'h1;
      wr(16'hFFC4, 8'h7C);
      st();
      `CK(pin_oe, 8'hFC)
      `CK({host_write_strobe, host_chip_select2, ext_int_pin1, ext_int_pin2}, 4'h0)
      `CK(adc_trigger_pin, 1'h1)
      `CK(ext_int_pin0, 1'h0)
      @(posedge ref_clk);
      slave_mode <= 1'h0;
      st();
      `CK({adc_trigger_pin, host_write_strobe, pin_oe[1:0]}, 4'h7)
      // Mode 3 with I2C enabled: pin 7 follows the I2C drive, wait enable is ignored
      @(posedge ref_clk);
      iic_sda_oe <= 1'h1;
      iic_sda_out <= 1'h1;
      wr(16'hFFC4, 8'h03);
      st();
      `CK({pin_oe[7], pin_o[7], wait_in, iic_sda_in}, 4'hF)
      @(posedge ref_clk);
      iic_sda_oe <= 1'h0;
      st();
      `CK({pin_oe[7], iic_sda_in}, 2'h0)
      test_done();
   end
endmodule
